// *** core/gpa_pkg.sv ***
// package for the eight-pin port with analog input disable
// assumes one system clock and an active-low asynchronous cpu reset
package gpa_pkg;

   // ----------------------------------------
   // port geometry and register addressing
   // ----------------------------------------
   localparam int unsigned PIN_N  = 8;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SYNC_N = 2;

   localparam logic [ADDR_W-1:0] OFS_DATA_LATCH = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_PULLUP     = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_AIN_DIS    = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_STANDBY    = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_CMP_CTRL   = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATE  = 3'h6;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int unsigned STANDBY_PIN_FLOAT_BIT   = 0;
   localparam int unsigned CMP_INPUT_DISABLE_BIT   = 0;
   localparam int unsigned CMP_PLUS_PIN            = 0;
   localparam int unsigned CMP_MINUS_PIN           = 1;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [DATA_W-1:0] RST_DATA_LATCH = 8'h00;
   localparam logic [DATA_W-1:0] RST_DIRECTION  = 8'h00;
   localparam logic [DATA_W-1:0] RST_PULLUP     = 8'h00;
   localparam logic [DATA_W-1:0] RST_AIN_DIS    = 8'h00;
   localparam logic              RST_PIN_FLOAT  = 1'b0;
   localparam logic              RST_CMP_DIS    = 1'b1;
   localparam logic [DATA_W-1:0] RD_UNMAPPED    = 8'h00;

endpackage : gpa_pkg

// *** core/gpa_sync_if.sv ***
// carrier between the port top and its pin synchroniser
// assumes both ends sit on the same system clock
`timescale 1ns/100ps
`default_nettype none

interface gpa_sync_if;
   import gpa_pkg::*;

   logic [PIN_N-1:0] raw;
   logic [PIN_N-1:0] synced;

   modport top  (output raw, input  synced);
   modport sync (input  raw, output synced);
endinterface : gpa_sync_if

`default_nettype wire

// *** core/gpa_pin_sync.sv ***
// two-stage synchroniser for every pad input of the port
// assumes pad levels may change at any time relative to i_mclk
`timescale 1ns/100ps
`default_nettype none

module gpa_pin_sync
   import gpa_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   gpa_sync_if.sync  sif
);

   // ----------------------------------------
   // per-pin flop pair
   // ----------------------------------------
   // stage one is read by stage two only
   genvar g;
   generate
      for (g = 0; g < PIN_N; g++)
      begin : g_pin
         logic meta_q;
         logic stab_q;

         always_ff @(posedge i_mclk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               meta_q <= 1'b0;
               stab_q <= 1'b0;
            end
            else
            begin
               meta_q <= sif.raw[g];
               stab_q <= meta_q;
            end
         end

         assign sif.synced[g] = stab_q;
      end
   endgenerate

endmodule : gpa_pin_sync

`default_nettype wire

// *** core/gpa_port.sv ***
// eight-pin general purpose port: latch, direction, pull-up, analog disable
// assumes cpu register port on i_mclk; peripheral and standby inputs synchronous
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none

module gpa_port
   import gpa_pkg::*;
(
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst_n,
   // register port
   input  wire logic [gpa_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [gpa_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   input  wire logic                       i_rmw,
   output var  logic [gpa_pkg::DATA_W-1:0] o_rdata,
   // pads
   input  wire logic [gpa_pkg::PIN_N-1:0]  i_pin,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_pin,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_pin_oe_n,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_pullup_en,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_analog_en,
   // shared peripheral functions
   input  wire logic [gpa_pkg::PIN_N-1:0]  i_periph_oe,
   input  wire logic [gpa_pkg::PIN_N-1:0]  i_periph_out,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_periph_in,
   // external interrupt circuit
   input  wire logic [gpa_pkg::PIN_N-1:0]  i_ext_irq_en,
   output var  logic [gpa_pkg::PIN_N-1:0]  o_ext_irq_level,
   // standby controller and comparator
   input  wire logic                       i_stop_or_watch,
   output var  logic                       o_comparator_plus_input_en,
   output var  logic                       o_comparator_minus_input_en
);
   import gpa_pkg::*;

   // ----------------------------------------
   // registers and synchroniser
   // ----------------------------------------
   logic [PIN_N-1:0] port_data_latch_q;
   logic [PIN_N-1:0] port_direction_q;
   logic [PIN_N-1:0] port_pullup_enable_q;
   logic [PIN_N-1:0] analog_input_disable_low_q;
   logic             standby_pin_float_q;
   logic             comparator_input_disable_q;
   logic [PIN_N-1:0] pin_sync;

   gpa_sync_if sif ();

   assign sif.raw  = i_pin;
   assign pin_sync = sif.synced;

   gpa_pin_sync u_sync (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .sif     (sif)
   );

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // latch takes every write regardless of direction
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         port_data_latch_q <= RST_DATA_LATCH;
      else if (i_wr && i_addr == OFS_DATA_LATCH)
         port_data_latch_q <= i_wdata;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         port_direction_q <= RST_DIRECTION;
      else if (i_wr && i_addr == OFS_DIRECTION)
         port_direction_q <= i_wdata;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         port_pullup_enable_q <= RST_PULLUP;
      else if (i_wr && i_addr == OFS_PULLUP)
         port_pullup_enable_q <= i_wdata;
   end

   // reset leaves shared analog pins with digital input off
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         analog_input_disable_low_q <= RST_AIN_DIS;
      else if (i_wr && i_addr == OFS_AIN_DIS)
         analog_input_disable_low_q <= i_wdata;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         standby_pin_float_q        <= RST_PIN_FLOAT;
         comparator_input_disable_q <= RST_CMP_DIS;
      end
      else if (i_wr)
      begin
         if (i_addr == OFS_STANDBY)
            standby_pin_float_q <= i_wdata[STANDBY_PIN_FLOAT_BIT];
         if (i_addr == OFS_CMP_CTRL)
            comparator_input_disable_q <= i_wdata[CMP_INPUT_DISABLE_BIT];
      end
   end

   // ----------------------------------------
   // pin behaviour
   // ----------------------------------------
   logic             float_act;
   logic [PIN_N-1:0] in_blocked;
   logic [PIN_N-1:0] drive_d;
   logic [PIN_N-1:0] level_d;
   logic [PIN_N-1:0] din;
   logic [PIN_N-1:0] irq_lvl;

   // without pin float, standby changes nothing here
   assign float_act  = standby_pin_float_q & i_stop_or_watch;
   assign in_blocked = {PIN_N{float_act}} & ~i_ext_irq_en;

   // peripheral output overrides the port latch
   assign drive_d = (port_direction_q | i_periph_oe) & {PIN_N{~float_act}};
   assign level_d = (i_periph_oe & i_periph_out)
                  | (~i_periph_oe & port_data_latch_q);

   // blocked inputs read low to avoid leakage from an open pad
   assign irq_lvl = pin_sync & ~in_blocked;
   assign din     = irq_lvl & analog_input_disable_low_q;

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pin      <= '0;
         o_pin_oe_n <= '1;
      end
      else
      begin
         o_pin      <= level_d;
         o_pin_oe_n <= ~drive_d;
      end
   end

   // pull-up off whenever the pad is pulled low by us
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_pullup_en <= '0;
      else
         o_pullup_en <= port_pullup_enable_q & ~(drive_d & ~level_d);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_analog_en     <= '1;
         o_periph_in     <= '0;
         o_ext_irq_level <= '0;
      end
      else
      begin
         o_analog_en     <= ~analog_input_disable_low_q;
         o_periph_in     <= din;
         o_ext_irq_level <= irq_lvl;
      end
   end

   // comparator path ignores data and direction settings
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_comparator_plus_input_en  <= 1'b0;
         o_comparator_minus_input_en <= 1'b0;
      end
      else
      begin
         o_comparator_plus_input_en  <= ~comparator_input_disable_q;
         o_comparator_minus_input_en <= ~comparator_input_disable_q;
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   logic [PIN_N-1:0]  pin_view;
   logic [DATA_W-1:0] rdata_d;

   // output pins show the latch, peripheral-driven pins the peripheral output; input pins the sampled level after analog disable and blocking
   assign pin_view = (port_direction_q & ~i_periph_oe & port_data_latch_q)
                   | (i_periph_oe & i_periph_out)
                   | (~port_direction_q & ~i_periph_oe & din);

   always_comb
   begin
      rdata_d = RD_UNMAPPED;
      unique case (i_addr)
         OFS_DATA_LATCH: rdata_d = i_rmw ? port_data_latch_q : pin_view;
         OFS_DIRECTION:  rdata_d = port_direction_q;
         OFS_PULLUP:     rdata_d = port_pullup_enable_q;
         OFS_AIN_DIS:    rdata_d = analog_input_disable_low_q;
         OFS_STANDBY:    rdata_d[STANDBY_PIN_FLOAT_BIT] = standby_pin_float_q;
         OFS_CMP_CTRL:   rdata_d[CMP_INPUT_DISABLE_BIT] = comparator_input_disable_q;
         OFS_PIN_STATE:  rdata_d = pin_sync;
         default:        rdata_d = RD_UNMAPPED;
      endcase
   end

   // data stand for one cycle after the read strobe only
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= '0;
      else if (i_rd)
         o_rdata <= rdata_d;
      else
         o_rdata <= '0;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   a_dir_out_drive: assert property (
      (port_direction_q[0] && !i_periph_oe[0] && !float_act)
      |=> (!o_pin_oe_n[0] && o_pin[0] == $past(port_data_latch_q[0])))
      else $error("output pin not driven from latch");

   a_dir_in_float: assert property (
      (!port_direction_q[0] && !i_periph_oe[0]) |=> o_pin_oe_n[0])
      else $error("input pin still driven");

   a_wr_latch_pin: assert property (
      (i_wr && i_addr == OFS_DATA_LATCH && port_direction_q == 8'hFF
       && i_periph_oe == 8'h00 && !float_act && !(i_wr && i_addr == OFS_DIRECTION))
      ##1 (i_periph_oe == 8'h00 && !float_act) |=> o_pin == $past(i_wdata, 2))
      else $error("output pins missed latch write");

   a_wr_latch_in: assert property (
      (i_wr && i_addr == OFS_DATA_LATCH)
      |=> port_data_latch_q == $past(i_wdata))
      else $error("latch not updated by data write");

   a_rmw_latch: assert property (
      (i_rd && i_rmw && i_addr == OFS_DATA_LATCH && !i_wr)
      |=> o_rdata == $past(port_data_latch_q))
      else $error("rmw read did not return latch");

   a_read_input: assert property (
      (i_rd && !i_rmw && i_addr == OFS_DATA_LATCH && port_direction_q == 8'h00
       && i_periph_oe == 8'h00 && analog_input_disable_low_q == 8'hFF && !float_act)
      |=> o_rdata == $past(pin_sync))
      else $error("input read not sampled pin level");

   a_periph_drive: assert property (
      (i_periph_oe[1] && !float_act) |=> (!o_pin_oe_n[1] && o_pin[1] == $past(i_periph_out[1])))
      else $error("peripheral output not on pin");

   a_ain_block: assert property (
      !analog_input_disable_low_q[2] |=> (!o_periph_in[2] && o_analog_en[2]))
      else $error("digital input not blocked on analog pin");

   a_float_hiz: assert property (
      (standby_pin_float_q && i_stop_or_watch)
      |=> (o_pin_oe_n == 8'hFF && (o_ext_irq_level & ~$past(i_ext_irq_en)) == 8'h00))
      else $error("pin float did not release pins");

   a_float_irq: assert property (
      (float_act && i_ext_irq_en[3]) |=> o_ext_irq_level[3] == $past(pin_sync[3]))
      else $error("interrupt pin input blocked in standby");

   a_pullup_low: assert property (
      (!o_pin_oe_n[4] && !o_pin[4]) |-> !o_pullup_en[4])
      else $error("pull-up connected while driving low");

   a_sync_delay: assert property (
      $rose(i_pin[5]) ##1 i_pin[5] ##1 i_pin[5] |-> pin_sync[5])
      else $error("synchroniser latency wrong");

   a_cmp_enable: assert property (
      !comparator_input_disable_q |=> (o_comparator_plus_input_en && o_comparator_minus_input_en))
      else $error("comparator input not enabled");

   a_nofloat_keep: assert property (
      !standby_pin_float_q |=> o_pin_oe_n == ~$past(port_direction_q | i_periph_oe))
      else $error("pins changed without pin float");

   a_irq_feed: assert property (
      !float_act |=> o_ext_irq_level == $past(pin_sync))
      else $error("pin level not fed to interrupt circuit");

   a_cmp_disable: assert property (
      comparator_input_disable_q
      |=> (!o_comparator_plus_input_en && !o_comparator_minus_input_en))
      else $error("comparator input not disabled");

   a_pullup_conn: assert property (
      (port_pullup_enable_q[4] && !(drive_d[4] && !level_d[4])) |=> o_pullup_en[4])
      else $error("pull-up not connected");

   a_ain_digital: assert property (
      (analog_input_disable_low_q[2] && !in_blocked[2])
      |=> (o_periph_in[2] == $past(pin_sync[2]) && !o_analog_en[2]))
      else $error("digital input not enabled on port pin");

   a_rd_out_latch: assert property (
      (i_rd && !i_rmw && i_addr == OFS_DATA_LATCH && port_direction_q[6] && !i_periph_oe[6])
      |=> o_rdata[6] == $past(port_data_latch_q[6]))
      else $error("output pin read did not return latch");

   c_output_write: cover property (i_wr && i_addr == OFS_DATA_LATCH && port_direction_q != 8'h00);
   c_rmw_read:     cover property (i_rd && i_rmw && i_addr == OFS_DATA_LATCH);
   c_float_irq:    cover property (float_act && i_ext_irq_en != 8'h00);
   c_periph_read:  cover property (i_rd && i_addr == OFS_DATA_LATCH && i_periph_oe != 8'h00);

endmodule : gpa_port

`default_nettype wire

// *** verification/gpa_pad_model.sv ***
// pad and far-side model for the eight-pin port
// assumes the port drives o_pin under an active-low enable on one system clock
`timescale 1ns/100ps
`default_nettype none

module gpa_pad_model
   import gpa_pkg::*;
(
   input  wire logic                      i_mclk,
   input  wire logic [gpa_pkg::PIN_N-1:0] i_pad_out,
   input  wire logic [gpa_pkg::PIN_N-1:0] i_pad_oe_n,
   input  wire logic [gpa_pkg::PIN_N-1:0] i_pullup_en,
   input  wire logic [gpa_pkg::PIN_N-1:0] i_ext_val,
   input  wire logic [gpa_pkg::PIN_N-1:0] i_ext_en,
   output var  logic [gpa_pkg::PIN_N-1:0] o_pad
);
   import gpa_pkg::*;

   // undriven, unpulled pad wanders every cycle so nothing settles by luck
   logic [PIN_N-1:0] wander_q = 8'h5A;

   always_ff @(posedge i_mclk)
   begin
      wander_q <= ~wander_q;
   end

   always_comb
   begin
      o_pad = (~i_pad_oe_n & i_pad_out)
            | (i_pad_oe_n & i_ext_en & i_ext_val)
            | (i_pad_oe_n & ~i_ext_en & i_pullup_en)
            | (i_pad_oe_n & ~i_ext_en & ~i_pullup_en & wander_q);
   end
endmodule : gpa_pad_model

`default_nettype wire

// *** verification/gpa_port_tb_top.sv ***
// self-checking bench for the eight-pin port
// assumes the pad model closes the pin loop; random stimulus from a fixed seed
`timescale 1ns/100ps
`default_nettype none

module gpa_port_tb_top;
   import gpa_pkg::*;

   logic              i_mclk;
   logic              i_rst_n;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata;
   logic              i_wr, i_rd, i_rmw, i_stop_or_watch;
   logic [PIN_N-1:0]  i_pin, o_pin, o_pin_oe_n, o_pullup_en, o_analog_en;
   logic [PIN_N-1:0]  i_periph_oe, i_periph_out, o_periph_in, i_ext_irq_en, o_ext_irq_level;
   logic [PIN_N-1:0]  ext_val, ext_en;
   logic              o_comparator_plus_input_en, o_comparator_minus_input_en;
   logic [31:0]       seed = 32'h00011B74;
   int                n_fail = 0;
   int                cmp_count = 0;

   gpa_port u_gpa_port (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_rmw(i_rmw), .o_rdata(o_rdata),
      .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_pullup_en(o_pullup_en),
      .o_analog_en(o_analog_en), .i_periph_oe(i_periph_oe), .i_periph_out(i_periph_out),
      .o_periph_in(o_periph_in), .i_ext_irq_en(i_ext_irq_en),
      .o_ext_irq_level(o_ext_irq_level), .i_stop_or_watch(i_stop_or_watch),
      .o_comparator_plus_input_en(o_comparator_plus_input_en),
      .o_comparator_minus_input_en(o_comparator_minus_input_en));

   gpa_pad_model u_gpa_pad_model (.i_mclk(i_mclk), .i_pad_out(o_pin),
      .i_pad_oe_n(o_pin_oe_n), .i_pullup_en(o_pullup_en), .i_ext_val(ext_val),
      .i_ext_en(ext_en), .o_pad(i_pin));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   function automatic logic [7:0] exp_read(input logic [7:0] poe, pout, dir, lat, pad, aid, blk);
      return (poe & pout) | (~poe & dir & lat) | (~poe & ~dir & pad & aid & ~blk);
   endfunction : exp_read

   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic chk_rd(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_rd

   task automatic chk_pad(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_pad

   // strobe stays high so writes may follow each other without a gap
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      i_rd <= 1'b0;
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic m, input logic [7:0] e,
                     input logic [7:0] mask);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      i_rmw <= m;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      i_rmw <= 1'b0;
      @(negedge i_mclk);
      chk_rd("rdata", e, o_rdata & mask);
      @(negedge i_mclk);
      chk_rd("rdata_idle", 8'h00, o_rdata);
      @(posedge i_mclk);
   endtask : rd

   // reset dropped just after an edge, held for n edges, outputs looked at off the edge
   task automatic reset_chk(input int n);
      i_rst_n <= 1'b0;
      repeat (n) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk_pad("oe_n", 8'hFF, o_pin_oe_n);
      chk_pad("analog_en", 8'hFF, o_analog_en);
      chk_pad("pullup", 8'h00, o_pullup_en);
      chk_pad("cmp_en", 8'h00,
              {6'h00, o_comparator_minus_input_en, o_comparator_plus_input_en});
      @(posedge i_mclk);
      rd(OFS_DIRECTION, 1'b0, RST_DIRECTION, 8'hFF);
      rd(OFS_AIN_DIS, 1'b0, RST_AIN_DIS, 8'hFF);
      rd(OFS_CMP_CTRL, 1'b0, 8'h01, 8'h01);
   endtask : reset_chk

   // ----------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   initial
   begin
      repeat (60000) @(posedge i_mclk);
      n_fail++;
      conclude();
   end

   initial
   begin
      logic [7:0] lat, dir, pul, aid, poe, pout, irq, drv, val, pad, blk, en;
      logic       spf, sow, cmpd, flt;
      {i_wr, i_rd, i_rmw, i_stop_or_watch} = 4'h0;
      i_addr = 3'h0;
      i_wdata = 8'h00;
      {i_periph_oe, i_periph_out, i_ext_irq_en} = 24'h000000;
      ext_val = 8'h00;
      ext_en = 8'hFF;
      reset_chk(20);
      wr(3'h7, 8'hFF);
      rd(3'h7, 1'b0, RD_UNMAPPED, 8'hFF);
      wr(OFS_DIRECTION, 8'hA5);
      rd(OFS_DIRECTION, 1'b0, 8'hA5, 8'hFF);
      // all pins out, then all in with digital input on
      ext_val <= 8'h96;
      wr(OFS_AIN_DIS, 8'hFF);
      wr(OFS_DIRECTION, 8'hFF);
      wr(OFS_DATA_LATCH, 8'h3C);
      i_wr <= 1'b0;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk_pad("pin_out", 8'h3C, o_pin);
      chk_pad("oe_n", 8'h00, o_pin_oe_n);
      @(posedge i_mclk);
      wr(OFS_DIRECTION, 8'h00);
      i_wr <= 1'b0;
      repeat (4) @(posedge i_mclk);
      rd(OFS_DATA_LATCH, 1'b0, 8'h96, 8'hFF);
      rd(OFS_DATA_LATCH, 1'b1, 8'h3C, 8'hFF);
      repeat (40)
      begin
         {lat, dir, pul, aid, pout} = {rnd(), rnd(), rnd(), rnd(), rnd()};
         {poe, irq, spf, sow, cmpd} = {rnd() & rnd(), rnd(), rnd() > 8'h80, rnd() > 8'h60,
                                       rnd() > 8'h80};
         wr(OFS_DATA_LATCH, lat);
         wr(OFS_DIRECTION, dir);
         wr(OFS_PULLUP, pul);
         wr(OFS_AIN_DIS, aid);
         wr(OFS_STANDBY, {7'h00, spf});
         wr(OFS_CMP_CTRL, {7'h00, cmpd});
         i_wr <= 1'b0;
         i_periph_oe <= poe;
         i_periph_out <= pout;
         i_ext_irq_en <= irq;
         i_stop_or_watch <= sow;
         ext_val <= rnd();
         // pins left by the far side always have their pull-up on
         en = rnd() | ~pul;
         ext_en <= en;
         repeat (5) @(posedge i_mclk);
         flt = spf & sow;
         drv = flt ? 8'h00 : (dir | poe);
         val = (poe & pout) | (~poe & lat);
         pad = (drv & val) | (~drv & ((en & ext_val) | (~en & pul)));
         blk = {8{flt}} & ~irq;
         @(negedge i_mclk);
         chk_pad("oe_n", ~drv, o_pin_oe_n);
         chk_pad("pin_out", drv & val, drv & o_pin);
         chk_pad("pullup", pul & ~(drv & ~val), o_pullup_en);
         chk_pad("analog_en", ~aid, o_analog_en);
         chk_pad("periph_in", pad & aid & ~blk, o_periph_in);
         chk_pad("irq_level", pad & ~blk, o_ext_irq_level);
         chk_pad("cmp_en", {6'h00, ~cmpd, ~cmpd},
                 {6'h00, o_comparator_minus_input_en, o_comparator_plus_input_en});
         @(posedge i_mclk);
         rd(OFS_DATA_LATCH, 1'b0, exp_read(poe, pout, dir, lat, pad, aid, blk), 8'hFF);
         rd(OFS_DATA_LATCH, 1'b1, lat, 8'hFF);
         rd(OFS_PIN_STATE, 1'b0, pad, 8'hFF);
         rd(OFS_PULLUP, 1'b0, pul, 8'hFF);
         rd(OFS_AIN_DIS, 1'b0, aid, 8'hFF);
         rd(OFS_STANDBY, 1'b0, {7'h00, spf}, 8'h01);
      end
      // second reset in mid-run must clear the random configuration
      {i_periph_oe, i_ext_irq_en, ext_en} <= 24'h0000FF;
      i_stop_or_watch <= 1'b0;
      reset_chk(3);
      conclude();
   end
endmodule : gpa_port_tb_top

`default_nettype wire
